// file: option_cfg_pkg.sv
package option_cfg_pkg;

    // Option byte 0 field positions
    localparam int HALT_WDG_BIT = 7;
    localparam int WDG_TYPE_BIT = 6;
    localparam int VD_HI_BIT = 4;
    localparam int VD_LO_BIT = 3;
    // Option byte 1 field positions
    localparam int PKG_BIT = 7;
    localparam int PLL_OFF_BIT = 0;
    localparam int OSC_RANGE_HI_BIT = 3;
    localparam int OSC_RANGE_LO_BIT = 1;

    // Erased array content
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Voltage detect encodings
    localparam logic [1:0] VD_HIGHEST = 2'h0;
    localparam logic [1:0] VD_MEDIUM = 2'h1;
    localparam logic [1:0] VD_LOWEST = 2'h2;
    localparam logic [1:0] VD_OFF = 2'h3;
    // Threshold one-hot outputs
    localparam logic [2:0] THR_HIGHEST = 3'h4;
    localparam logic [2:0] THR_MEDIUM = 3'h2;
    localparam logic [2:0] THR_LOWEST = 3'h1;
    localparam logic [2:0] THR_NONE = 3'h0;

    // AXI4-Lite register offsets
    localparam logic [3:0] OFS_OPT0 = 4'h0;
    localparam logic [3:0] OFS_OPT1 = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Capture sequencer states
    typedef enum logic [1:0] {
        LOAD_PHASE = 2'b00,
        RUN_PHASE = 2'b01
    } load_state_type;

endpackage : option_cfg_pkg

// file: option_byte_config_decoder.sv
module option_byte_config_decoder
    import option_cfg_pkg::*;
#(
    parameter logic PKG_DEFAULT = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    input wire logic PROG_MODE_I,
    input wire logic PROG_WE_I,
    input wire logic PROG_SEL_I,
    input wire logic [7:0] PROG_DATA_I,
    output logic [7:0] PROG_RDATA_O,
    input wire logic WATCHDOG_TYPE_SELECT_ENABLE_I,
    input wire logic HALT_ENTRY_I,
    output logic WATCHDOG_ACTIVE_O,
    output logic HALT_RESET_REQ_O,
    output logic [2:0] DETECT_THRESHOLD_O,
    output logic DETECTORS_ON_O,
    output logic PLL_ENABLE_O,
    output logic PACKAGE_SELECT_BIT_O,
    output logic CONFIG_VALID_O,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // Non-volatile store, no reset: contents persist, erased image is all ones except byte 1 bit 7, which is PKG_DEFAULT
    logic [7:0] nv_byte [2] = '{ERASED_BYTE, {PKG_DEFAULT, ERASED_BYTE[6:0]}};
    // Captured shadow of both bytes
    logic [7:0] opt0;
    logic [7:0] opt1;
    load_state_type state;
    // Programming pins pass two flops
    logic [11:0] prog_meta;
    logic [11:0] prog_sync;
    logic [1:0] halt_meta;
    logic [1:0] halt_sync;
    logic halt_prev;

    wire prog_mode = prog_sync[11];
    wire prog_we = prog_sync[10];
    wire prog_sel = prog_sync[9];
    wire [7:0] prog_data = prog_sync[7:0];
    wire watchdog_type_select_en = halt_sync[1];
    wire halt_now = halt_sync[0];

    // Synchronisers
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prog_meta <= 12'h000;
            prog_sync <= 12'h000;
            halt_meta <= 2'h0;
            halt_sync <= 2'h0;
        end else if (CE_I) begin
            prog_meta <= {PROG_MODE_I, PROG_WE_I, PROG_SEL_I, 1'b0, PROG_DATA_I};
            prog_sync <= prog_meta;
            halt_meta <= {WATCHDOG_TYPE_SELECT_ENABLE_I, HALT_ENTRY_I};
            halt_sync <= halt_meta;
        end
    end

    // Array written only from the programming port in programming mode
    wire nv_write = prog_mode && prog_we;

    // Array update from the programming port only
    always_ff @(posedge CLK_I) begin
        if (CE_I && nv_write) begin
            nv_byte[prog_sel] <= prog_data;
        end
    end

    // Capture sequencer: load once after reset release, then hold
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= LOAD_PHASE;
            opt0 <= ERASED_BYTE;
            opt1 <= ERASED_BYTE;
        end else if (CE_I) begin
            case (state)
                LOAD_PHASE: begin
                    opt0 <= nv_byte[0];
                    opt1 <= nv_byte[1];
                    state <= RUN_PHASE;
                end
                RUN_PHASE: begin
                    state <= RUN_PHASE;
                end
                default: begin
                    state <= LOAD_PHASE;
                end
            endcase
        end
    end

    wire loaded = (state == RUN_PHASE);

    // Decoding of the captured bytes
    wire hw_watchdog = ~opt0[WDG_TYPE_BIT];
    wire next_wdg_active = loaded && (hw_watchdog || watchdog_type_select_en);
    wire halt_edge = halt_now && !halt_prev;
    wire next_halt_reset = next_wdg_active && opt0[HALT_WDG_BIT] && halt_edge;
    wire [1:0] vd_field = opt0[VD_HI_BIT:VD_LO_BIT];
    wire [2:0] next_threshold = !loaded ? THR_NONE :
        (vd_field == VD_HIGHEST) ? THR_HIGHEST :
        (vd_field == VD_MEDIUM) ? THR_MEDIUM :
        (vd_field == VD_LOWEST) ? THR_LOWEST : THR_NONE;
    wire next_detect_on = loaded && (vd_field != VD_OFF);
    wire next_pll_en = loaded && !opt1[PLL_OFF_BIT];
    wire next_pkg = opt1[PKG_BIT];
    wire [7:0] next_prog_rdata = prog_mode ? nv_byte[prog_sel] : 8'h00;

    // Registered configuration outputs
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            halt_prev <= 1'b0;
            WATCHDOG_ACTIVE_O <= 1'b0;
            HALT_RESET_REQ_O <= 1'b0;
            DETECT_THRESHOLD_O <= THR_NONE;
            DETECTORS_ON_O <= 1'b0;
            PLL_ENABLE_O <= 1'b0;
            PACKAGE_SELECT_BIT_O <= 1'b0;
            CONFIG_VALID_O <= 1'b0;
            PROG_RDATA_O <= 8'h00;
        end else if (CE_I) begin
            halt_prev <= halt_now;
            WATCHDOG_ACTIVE_O <= next_wdg_active;
            HALT_RESET_REQ_O <= next_halt_reset;
            DETECT_THRESHOLD_O <= next_threshold;
            DETECTORS_ON_O <= next_detect_on;
            PLL_ENABLE_O <= next_pll_en;
            PACKAGE_SELECT_BIT_O <= next_pkg;
            CONFIG_VALID_O <= loaded;
            PROG_RDATA_O <= next_prog_rdata;
        end
    end

    // AXI4-Lite slave: read-only view of captured bytes and decoded status; writes refused
    logic aw_held;
    logic w_held;
    logic [3:0] ar_addr;
    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire both_in = (aw_held || aw_take) && (w_held || w_take);
    wire [31:0] status_word = {24'h0000_00, 1'b0, CONFIG_VALID_O, DETECTORS_ON_O,
        PLL_ENABLE_O, WATCHDOG_ACTIVE_O, DETECT_THRESHOLD_O};
    wire [31:0] next_rdata = (ar_addr == OFS_OPT0) ? {24'h0000_00, opt0} :
        (ar_addr == OFS_OPT1) ? {24'h0000_00, opt1} :
        (ar_addr == OFS_STATUS) ? status_word : 32'h0000_0000;
    wire rd_hit = (ar_addr == OFS_OPT0) || (ar_addr == OFS_OPT1) || (ar_addr == OFS_STATUS);
    logic rd_pend;

    // Write channel: every write answered with an error, nothing stored
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (CE_I) begin
            S_AXI_AWREADY <= !aw_held && !aw_take && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held && !w_take && !S_AXI_BVALID;
            if (both_in) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= RESP_SLVERR;
            end else begin
                aw_held <= aw_held || aw_take;
                w_held <= w_held || w_take;
                if (S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    // Read channel
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ar_addr <= 4'h0;
            rd_pend <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (CE_I) begin
            S_AXI_ARREADY <= !rd_pend && !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                ar_addr <= S_AXI_ARADDR;
                rd_pend <= 1'b1;
                S_AXI_ARREADY <= 1'b0;
            end else if (rd_pend) begin
                rd_pend <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= next_rdata;
                S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence halt_cause;
        CE_I && next_wdg_active && opt0[HALT_WDG_BIT] && halt_edge;
    endsequence

    chk_halt_reset_on: assert property (halt_cause |=> HALT_RESET_REQ_O)
        else $error("halt entry did not raise reset request");
    chk_halt_reset_off: assert property (CE_I && !opt0[HALT_WDG_BIT] |=> !HALT_RESET_REQ_O)
        else $error("reset raised with halt option clear");
    chk_hw_watchdog: assert property (CE_I && loaded && !opt0[WDG_TYPE_BIT] |=> WATCHDOG_ACTIVE_O)
        else $error("hardware watchdog not active");
    chk_vd_off: assert property (CE_I && loaded && vd_field == VD_OFF |=> !DETECTORS_ON_O && DETECT_THRESHOLD_O == THR_NONE)
        else $error("detectors not off");
    chk_vd_high: assert property (CE_I && loaded && vd_field == VD_HIGHEST |=> DETECT_THRESHOLD_O == THR_HIGHEST)
        else $error("highest threshold not chosen");
    chk_pll_map: assert property (CE_I && loaded |=> PLL_ENABLE_O == !$past(opt1[PLL_OFF_BIT]))
        else $error("pll enable does not follow option");
    chk_pkg_map: assert property (CE_I |=> PACKAGE_SELECT_BIT_O == $past(opt1[PKG_BIT]))
        else $error("package bit mismatch");
    chk_nv_lock: assert property (CE_I && !prog_mode |=> $stable(nv_byte[0]) && $stable(nv_byte[1]))
        else $error("array changed outside programming mode");
    chk_shadow_hold: assert property (loaded |=> $stable(opt0) && $stable(opt1))
        else $error("captured options changed after load");

endmodule : option_byte_config_decoder

// file: prog_tool_model.sv
module prog_tool_model #(
    parameter logic [2:0] RANGE_2_4MHZ = 3'h1 // Plain default, range encoding open
) (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic mode_o,
    output logic we_o,
    output logic sel_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins idle
    initial begin
        mode_o = 1'b0;
        we_o = 1'b0;
        sel_o = 1'b0;
        data_o = 8'h00;
    end

    // Write one option byte, returns the byte really sent
    task automatic write_byte(input logic sel, input logic [7:0] val, input logic mode, output logic [7:0] sent);
        sent = val;
        if (!sel) begin
            sent = sent | 8'h26; // Reserved bits kept at default
        end else if (!sent[0]) begin
            sent[3:1] = RANGE_2_4MHZ; // Doubler only with mid range
        end
        @(posedge clk_i);
        mode_o <= mode; // Mode pin as the caller asks; 0 tries a locked write
        we_o <= 1'b1;
        sel_o <= sel;
        data_o <= sent;
        repeat (4) @(posedge clk_i);
        we_o <= 1'b0;
        @(posedge clk_i);
        mode_o <= 1'b0;
        data_o <= ~sent; // Released line shows inverse
    endtask : write_byte

    // Read one option byte back in programming mode
    task automatic read_byte(input logic sel, output logic [7:0] val);
        @(posedge clk_i);
        mode_o <= 1'b1; // Access only in programming mode
        sel_o <= sel;
        repeat (4) @(posedge clk_i);
        val = rdata_i;
        mode_o <= 1'b0;
    endtask : read_byte
endmodule : prog_tool_model

// file: testbench.sv
module testbench
    import option_cfg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, swen, hent, pmode, pwe, psel, wact, hreq, don, pll, pkg, cval;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] pdata, prdata, b0, b1, n0, n1, rb;
    logic [2:0] thr;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    int seed, fail_count, n_compared;

    option_byte_config_decoder #(.PKG_DEFAULT(1'b1)) i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1),
        .PROG_MODE_I(pmode), .PROG_WE_I(pwe), .PROG_SEL_I(psel), .PROG_DATA_I(pdata), .PROG_RDATA_O(prdata),
        .WATCHDOG_TYPE_SELECT_ENABLE_I(swen), .HALT_ENTRY_I(hent), .WATCHDOG_ACTIVE_O(wact), .HALT_RESET_REQ_O(hreq),
        .DETECT_THRESHOLD_O(thr), .DETECTORS_ON_O(don), .PLL_ENABLE_O(pll), .PACKAGE_SELECT_BIT_O(pkg),
        .CONFIG_VALID_O(cval), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    prog_tool_model i_tool (.clk_i(clk), .rdata_i(prdata), .mode_o(pmode), .we_o(pwe), .sel_o(psel),
        .data_o(pdata));

    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Watchdog against hangs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Expected status {valid, detectors on, pll, watchdog active, threshold}
    function automatic logic [6:0] exp_status(input logic [7:0] o0, input logic [7:0] o1, input logic sw);
        logic [2:0] t;
        t = (o0[4:3] == 2'b00) ? 3'h4 : (o0[4:3] == 2'b01) ? 3'h2 : (o0[4:3] == 2'b10) ? 3'h1 : 3'h0;
        return {1'b1, o0[4:3] != 2'b11, !o1[0], !o0[6] | sw, t};
    endfunction : exp_status

    task automatic axi_write(input logic [3:0] a, output logic [1:0] resp);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= $random(seed);
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    task automatic check_all();
        logic [6:0] e;
        e = exp_status(b0, b1, swen);
        chk("cfg_out", 40'({cval, don, pll, wact, thr}), 40'(e));
        chk("pkg", 40'(pkg), 40'(b1[PKG_BIT]));
        axi_read(OFS_STATUS, d, r);
        chk("status", 40'({r, d[6:0]}), 40'({RESP_OKAY, e}));
        axi_read(OFS_OPT0, d, r);
        chk("opt0", 40'({r, d[7:0]}), 40'({RESP_OKAY, b0}));
        axi_read(OFS_OPT1, d, r);
        chk("opt1", 40'(d[7:0]), 40'(b1));
    endtask : check_all

    task automatic halt_check(input logic exp);
        logic [31:0] cnt;
        cnt = 32'h0000_0000;
        hent <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            cnt = cnt + 32'(hreq);
        end
        hent <= 1'b0;
        repeat (3) @(posedge clk);
        chk("halt_req", 40'(cnt), 40'(exp));
    endtask : halt_check

    // Main sequence
    initial begin
        seed = 8267;
        {rst_n, swen, hent, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, araddr, wdata} = 40'h00_0000_0000;
        fail_count = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        b0 = 8'hFF;
        b1 = 8'hFF;
        check_all();
        halt_check(1'b0);
        axi_write(OFS_OPT0, r);
        chk("wr_resp", 40'(r), 40'(RESP_SLVERR));
        axi_read(4'hC, d, r);
        chk("bad_rd", 40'({r, d}), 40'({RESP_SLVERR, 32'h0000_0000}));
        i_tool.write_byte(1'b0, 8'h00, 1'b0, n0);
        i_tool.read_byte(1'b0, rb);
        chk("locked", 40'(rb), 40'(8'hFF));
        for (int i = 0; i < 16; i++) begin
            n0 = 8'($random(seed));
            n1 = 8'($random(seed));
            n0[7:3] = {i[3:2], n0[5], i[1:0]};
            swen <= 1'($random(seed));
            i_tool.write_byte(1'b0, n0, 1'b1, n0);
            i_tool.write_byte(1'b1, n1, 1'b1, n1);
            check_all();
            i_tool.read_byte(1'b0, rb);
            chk("rd0", 40'(rb), 40'(n0));
            i_tool.read_byte(1'b1, rb);
            chk("rd1", 40'(rb), 40'(n1));
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            repeat (4) @(posedge clk);
            b0 = n0;
            b1 = n1;
            check_all();
            halt_check(b0[HALT_WDG_BIT] & (!b0[WDG_TYPE_BIT] | swen));
        end
        print_verdict();
    end
endmodule : testbench
